// File: rtl/plp_pkg.sv
/*
 Constants for the program lock protection block: register map, field
 positions, reset values and protection level codes.
 Assumes a single 40 MHz clock domain and a classic Wishbone master.
*/
package plp_pkg;
    localparam int CODE_AW = 13;
    localparam int ENC_AW = 6;
    localparam logic [7:0] ERASED_BYTE = 8'hFF;
    localparam logic [7:0] BLOCKED_BYTE = 8'hFF;
    localparam logic [7:0] VERIFY_OFF_BYTE = 8'h00;
    localparam logic [2:0] LOCK_ERASED = 3'h7;
    // Word offsets on the bus
    localparam logic [7:0] OFF_ADDR = 8'h00;
    localparam logic [7:0] OFF_DATA = 8'h04;
    localparam logic [7:0] OFF_CMD = 8'h08;
    localparam logic [7:0] OFF_STATUS = 8'h0C;
    localparam logic [7:0] OFF_VERIFY = 8'h10;
    // Command bits
    localparam int CMD_PROGRAM_PULSE_CODE = 0;
    localparam int CMD_PROGRAM_PULSE_ENC = 1;
    localparam int CMD_PROGRAM_PULSE_LOCK = 2;
    localparam int CMD_ERASE = 3;
    // Status bits
    localparam int ST_LEVEL = 0;
    localparam int ST_LOCK = 2;
    localparam int ST_EA = 5;
    localparam int ST_BUSY = 6;
    localparam int ST_REFUSED = 7;
    localparam logic [31:0] RESET_WORD = 32'h0000_0000;
    localparam logic [CODE_AW-1:0] CODE_LAST = 13'h1FFF;
    typedef enum logic [1:0] {
        PLP_L1 = 2'b00,
        PLP_L2 = 2'b01,
        PLP_L3 = 2'b10,
        PLP_L4 = 2'b11
    } plp_level_t;
endpackage : plp_pkg

// File: rtl/plp_top.sv
/*
 Program lock protection: code memory, encryption array, lock bits, the
 level decoder and the gates they drive on fetch, verify and programming.
 Assumes the CPU fetch port runs on clk_i; the external access pin is
 asynchronous. Storage cells have no reset, being nonvolatile: run an
 erase before relying on their contents.
*/
`timescale 1ns/10ps
module plp_top
    import plp_pkg::*;
(
    // Clock and reset
    input wire logic clk_i,
    input wire logic rst_i,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [7:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // CPU fetch path
    input wire logic fetch_req_i,
    input wire logic [CODE_AW-1:0] fetch_addr_i,
    input wire logic code_table_read_i,
    input wire logic fetch_from_external_i,
    output logic [7:0] fetch_data_o,
    output logic fetch_valid_o,
    output logic fetch_blocked_o,
    // Pins and protection state
    input wire logic external_access_pin_i,
    output logic ea_effective_o,
    output logic ext_exec_en_o,
    output logic [1:0] level_o
);
    ////////////////////////////////////////////////////////////////////////
    // Storage, nonvolatile so no reset
    logic [7:0] code_mem [0:(1<<CODE_AW)-1];
    logic [7:0] enc_mem [0:(1<<ENC_AW)-1];
    logic lock_bit_first_q;
    logic lock_bit_second_q;
    logic lock_bit_third_q;

    logic [CODE_AW-1:0] addr_q;
    logic [7:0] data_q;
    logic ack_q;
    logic [31:0] dat_q;
    logic busy_q;
    logic [CODE_AW-1:0] erase_cnt_q;
    logic refused_q;
    plp_level_t level_q;
    logic ea_s1_q, ea_s2_q, ea_latched_q, rst_seen_q, ea_eff_q;
    logic [7:0] fdata_q;
    logic fvalid_q, fblock_q, ext_en_q;

    ////////////////////////////////////////////////////////////////////////
    // Decode
    function automatic plp_level_t decode_level(input logic [2:0] lb);
        case (lb)
            3'b111: decode_level = PLP_L1;
            3'b110: decode_level = PLP_L2;
            3'b100: decode_level = PLP_L3;
            3'b000: decode_level = PLP_L4;
            default: decode_level = PLP_L4;
        endcase
    endfunction : decode_level

    wire [2:0] lock_bits = {lock_bit_third_q, lock_bit_second_q, lock_bit_first_q};
    wire wb_req = wb_cyc_i && wb_stb_i && !ack_q;
    wire wb_wr = wb_req && wb_we_i && wb_sel_i[0];
    wire wr_addr = wb_wr && wb_adr_i == OFF_ADDR;
    wire wr_data = wb_wr && wb_adr_i == OFF_DATA;
    wire wr_cmd = wb_wr && wb_adr_i == OFF_CMD && !busy_q;
    wire wr_status = wb_wr && wb_adr_i == OFF_STATUS;
    wire locked = level_q != PLP_L1;
    wire program_pulse_code = wr_cmd && wb_dat_i[CMD_PROGRAM_PULSE_CODE] && !locked;
    wire program_pulse_enc = wr_cmd && wb_dat_i[CMD_PROGRAM_PULSE_ENC] && !locked;
    wire program_pulse_lock = wr_cmd && wb_dat_i[CMD_PROGRAM_PULSE_LOCK];
    wire start_erase = wr_cmd && wb_dat_i[CMD_ERASE];
    wire refuse = wr_cmd && locked && (wb_dat_i[CMD_PROGRAM_PULSE_CODE] || wb_dat_i[CMD_PROGRAM_PULSE_ENC]);
    // Encrypted verify byte; unprogrammed array gives the raw code
    wire [7:0] verify_raw = ~(code_mem[addr_q] ^ enc_mem[addr_q[ENC_AW-1:0]]);
    wire verify_off = level_q == PLP_L3 || level_q == PLP_L4;
    wire [7:0] verify_byte = verify_off ? VERIFY_OFF_BYTE : verify_raw;
    wire [31:0] status_word = {24'h00_0000, refused_q, busy_q, ea_eff_q, lock_bits, level_q};
    wire [31:0] rd_word = wb_adr_i == OFF_ADDR ? {19'h0_0000, addr_q} :
                          wb_adr_i == OFF_DATA ? {24'h00_0000, data_q} :
                          wb_adr_i == OFF_STATUS ? status_word :
                          wb_adr_i == OFF_VERIFY ? {24'h00_0000, verify_byte} : RESET_WORD;
    // Table read from external code may not see internal bytes once locked
    wire table_block = code_table_read_i && fetch_from_external_i && locked;
    wire ea_hold = locked;
    wire ea_next = ea_hold ? ea_latched_q : ea_s2_q;

    ////////////////////////////////////////////////////////////////////////
    // Bus slave
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= RESET_WORD;
            addr_q <= '0;
            data_q <= ERASED_BYTE;
        end else begin
            ack_q <= wb_req;
            if (wb_req) dat_q <= rd_word;
            if (wr_addr) addr_q <= wb_dat_i[CODE_AW-1:0];
            if (wr_data) data_q <= wb_dat_i[7:0];
        end
    end

    // Set wins over the write-one clear
    always_ff @(posedge clk_i) begin
        if (rst_i) refused_q <= 1'b0;
        else refused_q <= refuse || (refused_q && !(wr_status && wb_dat_i[ST_REFUSED]));
    end

    ////////////////////////////////////////////////////////////////////////
    // Programming and erase; programming only takes cells from one to zero
    always_ff @(posedge clk_i) begin
        if (busy_q) code_mem[erase_cnt_q] <= ERASED_BYTE;
        else if (program_pulse_code) code_mem[addr_q] <= code_mem[addr_q] & data_q;
    end

    always_ff @(posedge clk_i) begin
        if (start_erase) begin
            for (int i = 0; i < (1<<ENC_AW); i++) enc_mem[i] <= ERASED_BYTE;
        end else if (program_pulse_enc) begin
            enc_mem[addr_q[ENC_AW-1:0]] <= enc_mem[addr_q[ENC_AW-1:0]] & data_q;
        end
    end

    // One pulse programs the addressed lock bit; the count is the programmer's
    always_ff @(posedge clk_i) begin
        if (start_erase) begin
            {lock_bit_third_q, lock_bit_second_q, lock_bit_first_q} <= LOCK_ERASED;
        end else if (program_pulse_lock) begin
            if (addr_q[1:0] == 2'd0) lock_bit_first_q <= 1'b0;
            if (addr_q[1:0] == 2'd1) lock_bit_second_q <= 1'b0;
            if (addr_q[1:0] == 2'd2) lock_bit_third_q <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            busy_q <= 1'b0;
            erase_cnt_q <= '0;
        end else if (start_erase) begin
            busy_q <= 1'b1;
            erase_cnt_q <= '0;
        end else if (busy_q) begin
            busy_q <= erase_cnt_q != CODE_LAST;
            erase_cnt_q <= erase_cnt_q + 1'b1;
        end
    end

    // Level follows the cells every cycle after reset
    always_ff @(posedge clk_i) begin
        if (rst_i) level_q <= PLP_L4;
        else level_q <= decode_level(lock_bits);
    end

    ////////////////////////////////////////////////////////////////////////
    // External access pin: synchronise, catch right after reset release
    always_ff @(posedge clk_i) begin
        ea_s1_q <= external_access_pin_i;
        ea_s2_q <= ea_s1_q;
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            rst_seen_q <= 1'b1;
            ea_latched_q <= 1'b0;
            ea_eff_q <= 1'b0;
        end else begin
            rst_seen_q <= 1'b0;
            if (rst_seen_q) ea_latched_q <= ea_s2_q;
            ea_eff_q <= rst_seen_q ? ea_s2_q : ea_next;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Fetch port
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            fdata_q <= BLOCKED_BYTE;
            fvalid_q <= 1'b0;
            fblock_q <= 1'b0;
            ext_en_q <= 1'b0;
        end else begin
            fvalid_q <= fetch_req_i;
            fblock_q <= fetch_req_i && table_block;
            if (fetch_req_i) fdata_q <= table_block ? BLOCKED_BYTE : code_mem[fetch_addr_i];
            ext_en_q <= level_q != PLP_L4;
        end
    end

    assign wb_ack_o = ack_q;
    assign wb_dat_o = dat_q;
    assign fetch_data_o = fdata_q;
    assign fetch_valid_o = fvalid_q;
    assign fetch_blocked_o = fblock_q;
    assign ea_effective_o = ea_eff_q;
    assign ext_exec_en_o = ext_en_q;
    assign level_o = level_q;

    ////////////////////////////////////////////////////////////////////////
    // Checks
    default clocking cb @(posedge clk_i); endclocking
    default disable iff (rst_i);

    sequence s_erase_cmd;
        wr_cmd && wb_dat_i[CMD_ERASE];
    endsequence
    sequence s_locks_clear;
        lock_bits == LOCK_ERASED ##1 level_q == PLP_L1;
    endsequence

    a_erase_locks: assert property (s_erase_cmd |=> s_locks_clear)
        else $error("erase did not clear lock bits");
    a_erase_walk: assert property (s_erase_cmd |=> busy_q [*8])
        else $error("erase walk ended early");
    a_program_pulse_refused: assert property (wr_cmd && wb_dat_i[CMD_PROGRAM_PULSE_CODE] && locked |=> refused_q)
        else $error("locked code program not refused");
    a_verify_off: assert property (wb_req && !wb_we_i && wb_adr_i == OFF_VERIFY && verify_off
        |=> wb_ack_o && wb_dat_o == {24'h00_0000, VERIFY_OFF_BYTE})
        else $error("verify readout at level 3 or 4");
    a_table_block: assert property (fetch_req_i && table_block |=> fetch_blocked_o
        && fetch_data_o == BLOCKED_BYTE)
        else $error("table read leaked internal code");
    a_ext_exec_off: assert property (level_q == PLP_L4 |=> !ext_exec_en_o)
        else $error("external execution at level 4");
    a_level_free: assert property (level_q == PLP_L1 |=> ext_exec_en_o)
        else $error("restriction at level 1");
    a_ea_held: assert property (!rst_seen_q && locked && $stable(level_q) ##1 locked
        |-> $stable(ea_effective_o))
        else $error("latched access pin changed");
    a_level_decode: assert property (lock_bits == 3'b110 |=> level_q == PLP_L2)
        else $error("lock bit decode wrong");
    a_ack_once: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held two cycles");
endmodule : plp_top

// File: tb/plp_fetch_model.sv
/*
 CPU fetch side model: turns a one-cycle go from the bench into one fetch.
 Assumes the bench drives go and its fields at rising edges of clk_i.
*/
`timescale 1ns/10ps
module plp_fetch_model
    import plp_pkg::*;
(
    // Clock and bench side
    input wire logic clk_i,
    input wire logic go_i,
    input wire logic [CODE_AW-1:0] addr_i,
    input wire logic table_i,
    input wire logic ext_i,
    // Fetch side
    output logic req_o,
    output logic [CODE_AW-1:0] addr_o,
    output logic table_o,
    output logic ext_o
);
    // One process owns each register; start values sit in the declarations
    logic req_q = 1'b0;
    logic [CODE_AW-1:0] addr_q = '0;
    logic table_q = 1'b0;
    logic ext_q = 1'b0;
    // Idle fields toggle so a stale value is never mistaken for a request
    always @(posedge clk_i) begin
        req_q <= go_i;
        addr_q <= go_i ? addr_i : ~addr_q;
        table_q <= go_i ? table_i : ~table_q;
        ext_q <= go_i ? ext_i : ~ext_q;
    end
    assign req_o = req_q;
    assign addr_o = addr_q;
    assign table_o = table_q;
    assign ext_o = ext_q;
endmodule : plp_fetch_model

// File: tb/program_lock_protection_bench.sv
/*
 Bench for plp_top: Wishbone tasks, fetches through plp_fetch_model,
 expected results queued and checked by a monitor. Assumes plp_pkg.
*/
`timescale 1ns/10ps
module program_lock_protection_bench;
    import plp_pkg::*;
    logic clk_i = 0, rst_i = 1, cyc = 0, stb = 0, we = 0, go = 0, tbl = 0, ext = 0, pin = 0;
    logic [7:0] adr = 8'h00, fdat, d, e;
    logic [31:0] wdat = 32'h0000_0000, rnd = 32'he629, dat_o, rd;
    logic [CODE_AW-1:0] faddr = '0, fa, a;
    logic req, ftbl, fext, ack, fvalid, fblk, ea_eff, ext_en;
    logic [1:0] level;
    logic [63:0] rdq[$], q;
    logic [8:0] fq[$];
    int miscompares = 0, comparisons = 0;

    plp_top i_plp_top (.clk_i(clk_i), .rst_i(rst_i), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
        .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(wdat), .wb_dat_o(dat_o), .wb_ack_o(ack),
        .fetch_req_i(req), .fetch_addr_i(fa), .code_table_read_i(ftbl), .fetch_from_external_i(fext),
        .fetch_data_o(fdat), .fetch_valid_o(fvalid), .fetch_blocked_o(fblk),
        .external_access_pin_i(pin), .ea_effective_o(ea_eff), .ext_exec_en_o(ext_en), .level_o(level));
    plp_fetch_model i_plp_fetch_model (.clk_i(clk_i), .go_i(go), .addr_i(faddr), .table_i(tbl),
        .ext_i(ext), .req_o(req), .addr_o(fa), .table_o(ftbl), .ext_o(fext));

    initial forever #12.5 clk_i = ~clk_i;

    ////////////////////////////////////////////////////////////////
    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction : lfsr
    task automatic chk(input string n, input logic [31:0] x, input logic [31:0] g);
        comparisons++;
        if (g !== x) begin
            miscompares++;
            $display("[FAIL] %s expected %h seen %h", n, x, g);
        end
    endtask : chk
    task automatic results;
        if (miscompares == 0 && comparisons > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask : results
    // Reads queue masked expectations; mask 0 means poll only
    task automatic bus(input logic w, input logic [7:0] ad, input logic [31:0] dt,
        input logic [31:0] m, output logic [31:0] r);
        int n;
        if (!w) rdq.push_back({m, dt & m});
        @(posedge clk_i);
        {cyc, stb, we, adr, wdat} <= {2'h3, w, ad, dt};
        n = 0;
        do begin
            @(posedge clk_i);
            n++;
            if (n > 50) begin
                miscompares++;
                results();
            end
        end while (ack !== 1'b1);
        r = dat_o;
        {cyc, stb, we} <= 3'h0;
    endtask : bus
    task automatic program_pulse(input int b, input logic [12:0] ad, input logic [7:0] dt, input int p);
        bus(1, OFF_ADDR, 32'(ad), 0, rd);
        bus(1, OFF_DATA, 32'(dt), 0, rd);
        repeat (p) bus(1, OFF_CMD, 32'h0000_0001 << b, 0, rd);
    endtask : program_pulse
    task automatic erase;
        int n;
        bus(1, OFF_CMD, 32'h0000_0001 << CMD_ERASE, 0, rd);
        // Ignored while busy; lock status after the erase shows a leak
        bus(1, OFF_CMD, 32'h0000_0001 << CMD_PROGRAM_PULSE_LOCK, 0, rd);
        for (n = 0; n < 4000; n++) begin
            bus(0, OFF_STATUS, 0, 0, rd);
            if (rd[ST_BUSY] === 1'b0) break;
        end
        if (n == 4000) begin
            miscompares++;
            results();
        end
    endtask : erase
    task automatic fetch(input logic [12:0] ad, input logic t, input logic x, input logic [8:0] exp);
        fq.push_back(exp);
        @(posedge clk_i);
        {go, faddr, tbl, ext} <= {1'b1, ad, t, x};
        @(posedge clk_i);
        go <= 0;
        repeat (3) @(posedge clk_i);
    endtask : fetch
    task automatic reset_pulse;
        @(posedge clk_i);
        rst_i <= 1;
        repeat (3) @(posedge clk_i);
        rst_i <= 0;
        repeat (5) @(posedge clk_i);
    endtask : reset_pulse
    task automatic verify(input logic [31:0] x);
        bus(1, OFF_ADDR, 32'(a), 0, rd);
        bus(0, OFF_VERIFY, x, 32'h0000_00FF, rd);
    endtask : verify

    ////////////////////////////////////////////////////////////////
    always @(posedge clk_i) begin
        if (ack === 1'b1 && we === 1'b0 && rdq.size() > 0) begin
            q = rdq.pop_front();
            if (q[63:32] != 0) chk("wb_dat_o", q[31:0], dat_o & q[63:32]);
        end
        if (fvalid === 1'b1) chk("fetch", fq.size() > 0 ? fq.pop_front() : 9'h1FF, {fblk, fdat});
    end

    initial begin
        repeat (20) @(posedge clk_i);
        rst_i <= 0;
        repeat (3) @(posedge clk_i);
        erase();
        bus(0, OFF_STATUS, 32'h0000_001C, 32'h0000_001F, rd);
        rnd = lfsr(lfsr(rnd));
        {e, d, a} = rnd[28:0];
        program_pulse(CMD_PROGRAM_PULSE_CODE, a, d, 5);
        program_pulse(CMD_PROGRAM_PULSE_ENC, a, e, 25);
        verify(32'(~(d ^ e)));
        fetch(a, 1, 1, {1'b0, d});
        chk("ext_exec_en_o", 1, ext_en);
        pin <= 1;
        repeat (6) @(posedge clk_i);
        chk("ea_effective_o", 1, ea_eff);
        program_pulse(CMD_PROGRAM_PULSE_LOCK, 0, 0, 25);
        reset_pulse();
        pin <= 0;
        repeat (6) @(posedge clk_i);
        chk("ea_effective_o", 1, ea_eff);
        chk("level_o", PLP_L2, level);
        bus(0, OFF_STATUS, 32'h0000_0019, 32'h0000_001F, rd);
        fetch(a, 1, 1, {1'b1, 8'hFF});
        fetch(a, 1, 0, {1'b0, d});
        program_pulse(CMD_PROGRAM_PULSE_CODE, a, 8'h00, 5);
        bus(0, OFF_STATUS, 32'h0000_0080, 32'h0000_0080, rd);
        bus(1, OFF_STATUS, 32'h0000_0080, 0, rd);
        bus(0, OFF_STATUS, 32'h0000_0000, 32'h0000_0080, rd);
        verify(32'(~(d ^ e)));
        bus(0, 8'h40, 32'h0000_0000, 32'hFFFF_FFFF, rd);
        program_pulse(CMD_PROGRAM_PULSE_LOCK, 1, 0, 25);
        reset_pulse();
        bus(0, OFF_STATUS, 32'h0000_0012, 32'h0000_001F, rd);
        verify(32'(VERIFY_OFF_BYTE));
        fetch(a, 1, 1, {1'b1, 8'hFF});
        program_pulse(CMD_PROGRAM_PULSE_LOCK, 2, 0, 25);
        reset_pulse();
        chk("level_o", PLP_L4, level);
        chk("ext_exec_en_o", 0, ext_en);
        erase();
        bus(0, OFF_STATUS, 32'h0000_001C, 32'h0000_001F, rd);
        verify(32'h0000_00FF);
        program_pulse(CMD_PROGRAM_PULSE_CODE, a, d, 5);
        verify(32'(d));
        repeat (5) @(posedge clk_i);
        chk("pending", 0, fq.size() + rdq.size());
        results();
    end
endmodule : program_lock_protection_bench
